// File: inc/cqw_regs.svh
// Register offsets, field positions and reset values of the queue writer
`ifndef CQW_REGS_SVH
`define CQW_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CQW_ADR_CTRL 8'h00
`define CQW_ADR_QLEN 8'h04
`define CQW_ADR_PERIOD 8'h08
`define CQW_ADR_FID 8'h0C
`define CQW_ADR_FKIND 8'h10
`define CQW_ADR_FDAT0 8'h14
`define CQW_ADR_FDAT1 8'h18
`define CQW_ADR_ENQ 8'h1C
`define CQW_ADR_STAT 8'h20
`define CQW_ADR_ISR 8'h24
`define CQW_ADR_IMR 8'h28

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CQW_CTRL_RUN 0
`define CQW_CTRL_PERIODIC 1
`define CQW_FKIND_LEN_LSB 8
`define CQW_EXT_BIT 29
`define CQW_STAT_COUNT_LSB 8
`define CQW_IRQ_OVF 0
`define CQW_IRQ_SIZE 1
`define CQW_IRQ_KIND 2
`define CQW_IRQ_SENT 3
`define CQW_IRQ_W 4

// ----------------------------------------------------------------------
// Reset values and fixed figures
// ----------------------------------------------------------------------
`define CQW_CTRL_RST 2'h0
`define CQW_QLEN_RST 8'h08
`define CQW_PERIOD_RST 16'h03E8
`define CQW_ITEM_SIZE 8'h18
`define CQW_MAX_PAYLOAD 8'h08
`define CQW_MAX_DLC 8'h0F

`endif

// File: inc/cqw_pkg.sv
// Types shared by the transmit queue writer
package cqw_pkg;

	// Frame kinds carried in the frame record
	typedef enum logic [7:0] {
		CQW_KIND_DATA = 8'h00,
		CQW_KIND_REMOTE = 8'h01,
		CQW_KIND_RESP_ENTRY = 8'h10,
		CQW_KIND_HEADER = 8'h11,
		CQW_KIND_FULL = 8'h12
	} cqw_kind_t;

	// Transmit sequencer, Gray coded
	typedef enum logic [1:0] {
		CQW_ST_IDLE = 2'b00,
		CQW_ST_SEND = 2'b01
	} cqw_state_t;

endpackage : cqw_pkg

// File: rtl/cqw_tx_queue.sv
// Transmit frame queue with Wishbone registers and periodic resend
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "cqw_regs.svh"

module cqw_tx_queue import cqw_pkg::*; #(
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq,
	output logic tx_valid,
	output logic [28:0] tx_ident,
	output logic tx_extended,
	output logic tx_remote,
	output logic [3:0] tx_dlc,
	output logic [63:0] tx_data,
	input wire logic tx_done,
	input wire logic tx_arb_won,
	input wire logic tx_acked
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	default clocking cb_a @(posedge clock); endclocking
	default disable iff (!reset_n);

	// ------------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------------
	// Pointers wrap by overflow, so only powers of two are served
	if (DEPTH < 2 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("DEPTH must be a power of two from 2 to 128");
	end

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic ack_q;
	logic [31:0] dat_q;
	logic [1:0] ctrl_q;
	logic run_d1_q;
	logic [7:0] qlen_q;
	logic [15:0] period_q;
	logic [31:0] fid_q;
	logic [15:0] fkind_q;
	logic [63:0] fdat_q;
	logic [`CQW_IRQ_W-1:0] isr_q;
	logic [`CQW_IRQ_W-1:0] imr_q;
	logic [`CQW_IRQ_W-1:0] isr_set;
	logic [31:0] q_id [DEPTH];
	logic [15:0] q_kind [DEPTH];
	logic [63:0] q_data [DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [PW:0] count_q;
	logic txc_q;
	logic last_valid_q;
	logic [15:0] tick_cnt_q;
	cqw_state_t state_q;
	logic hit, wr_en, enq_req, size_ok, kind_ok, full, zero_mode;
	logic accept, overwrite, push, pop, start_tx, tick, sent_ok;
	logic run, periodic, run_rise, ovf_ev;
	logic [7:0] new_kind, new_len;

	// ------------------------------------------------------------------
	// Byte-lane merge for register writes
	// ------------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Clear payload bytes beyond the length field
	function automatic logic [63:0] len_mask(input logic [63:0] d,
		input logic [7:0] len);
		logic [63:0] r;
		r = 64'h0;
		for (int i = 0; i < 8; i++) begin
			if (8'(i) < len) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : len_mask

	// ------------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------------
	// Ack one cycle after the strobe; writes act on the ack edge
	assign hit = wb_cyc_i & wb_stb_i;
	assign wr_en = hit & wb_we_i & ack_q;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= hit & ~ack_q;
		end
	end

	// Read mux sampled into a flop; unmapped reads return zero
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			dat_q <= 32'h0;
		end else if (hit & ~ack_q & ~wb_we_i) begin
			case (wb_adr_i)
				`CQW_ADR_CTRL: dat_q <= {30'h0, ctrl_q};
				`CQW_ADR_QLEN: dat_q <= {24'h0, qlen_q};
				`CQW_ADR_PERIOD: dat_q <= {16'h0, period_q};
				`CQW_ADR_FID: dat_q <= fid_q;
				`CQW_ADR_FKIND: dat_q <= {16'h0, fkind_q};
				`CQW_ADR_FDAT0: dat_q <= fdat_q[31:0];
				`CQW_ADR_FDAT1: dat_q <= fdat_q[63:32];
				`CQW_ADR_STAT: dat_q <= {{(23-PW){1'b0}}, count_q,
					6'h0, (state_q == CQW_ST_SEND), txc_q};
				`CQW_ADR_ISR: dat_q <= {{(32-`CQW_IRQ_W){1'b0}}, isr_q};
				`CQW_ADR_IMR: dat_q <= {{(32-`CQW_IRQ_W){1'b0}}, imr_q};
				default: dat_q <= 32'h0;
			endcase
		end
	end

	// Setting registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= `CQW_CTRL_RST;
			qlen_q <= `CQW_QLEN_RST;
			period_q <= `CQW_PERIOD_RST;
			fid_q <= 32'h0;
			fkind_q <= 16'h0;
			fdat_q <= 64'h0;
			imr_q <= '0;
		end else if (wr_en) begin
			case (wb_adr_i)
				`CQW_ADR_CTRL: ctrl_q <= wb_sel_i[0] ? wb_dat_i[1:0] : ctrl_q;
				`CQW_ADR_QLEN: qlen_q <= wb_sel_i[0] ?
					wb_dat_i[7:0] : qlen_q;
				`CQW_ADR_PERIOD: period_q <= 16'(merge({16'h0, period_q},
					wb_dat_i, wb_sel_i));
				`CQW_ADR_FID: fid_q <= merge(fid_q, wb_dat_i, wb_sel_i);
				`CQW_ADR_FKIND: fkind_q <= 16'(merge({16'h0, fkind_q},
					wb_dat_i, wb_sel_i));
				`CQW_ADR_FDAT0: fdat_q[31:0] <= merge(fdat_q[31:0],
					wb_dat_i, wb_sel_i);
				`CQW_ADR_FDAT1: fdat_q[63:32] <= merge(fdat_q[63:32],
					wb_dat_i, wb_sel_i);
				`CQW_ADR_IMR: imr_q <= wb_sel_i[0] ?
					wb_dat_i[`CQW_IRQ_W-1:0] : imr_q;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Enqueue decode
	// ------------------------------------------------------------------
	assign run = ctrl_q[`CQW_CTRL_RUN];
	assign periodic = ctrl_q[`CQW_CTRL_PERIODIC];
	assign run_rise = run & ~run_d1_q;
	assign new_kind = fkind_q[7:0];
	assign new_len = fkind_q[`CQW_FKIND_LEN_LSB +: 8];
	assign enq_req = wr_en & (wb_adr_i == `CQW_ADR_ENQ) & wb_sel_i[0];
	assign size_ok = (wb_dat_i[7:0] == `CQW_ITEM_SIZE);
	// Only CAN data and remote kinds are sent; other kinds refused
	assign kind_ok = (new_kind == CQW_KIND_DATA &&
		new_len <= `CQW_MAX_PAYLOAD) ||
		(new_kind == CQW_KIND_REMOTE && new_len <= `CQW_MAX_DLC);
	assign zero_mode = (qlen_q == 8'h00);
	assign full = ({{(7-PW){1'b0}}, count_q} >= qlen_q) ||
		(count_q == (PW+1)'(DEPTH));
	assign ovf_ev = enq_req & size_ok & kind_ok & ~zero_mode & full;
	assign accept = enq_req & size_ok & kind_ok & (zero_mode | ~full);
	// Overwrite the held item unless it is leaving this same cycle
	assign overwrite = accept & zero_mode & (count_q != '0) & ~pop;
	assign push = accept & ~overwrite;

	// ------------------------------------------------------------------
	// Queue storage, first in first out
	// ------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (push | overwrite) begin
			q_id[overwrite ? rd_ptr_q : wr_ptr_q] <= fid_q;
			q_kind[overwrite ? rd_ptr_q : wr_ptr_q] <= fkind_q;
			q_data[overwrite ? rd_ptr_q : wr_ptr_q] <= fdat_q;
		end
	end

	// Pointers and fill count; enqueue never waits for the bus
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// ------------------------------------------------------------------
	// Period divider
	// ------------------------------------------------------------------
	// One-cycle enable each period; a period of zero acts as one
	assign tick = periodic & run & (tick_cnt_q == 16'h0);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt_q <= 16'h0;
		end else if (!(periodic & run) || tick_cnt_q == 16'h0) begin
			tick_cnt_q <= (period_q == 16'h0) ? 16'h0 : period_q - 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q - 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Transmit sequencer
	// ------------------------------------------------------------------
	// A missed tick while busy is dropped, not queued up
	assign start_tx = (state_q == CQW_ST_IDLE) & run &
		(periodic ? tick & ((count_q != '0) | last_valid_q)
		: (count_q != '0));
	assign pop = start_tx & (count_q != '0);
	assign sent_ok = (state_q == CQW_ST_SEND) & tx_done &
		tx_arb_won & tx_acked;
	assign tx_valid = (state_q == CQW_ST_SEND);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= CQW_ST_IDLE;
		end else begin
			case (state_q)
				CQW_ST_IDLE: begin
					if (start_tx) begin
						state_q <= CQW_ST_SEND;
					end
				end
				// Lost arbitration or no acknowledge: try again
				CQW_ST_SEND: begin
					if (sent_ok) begin
						state_q <= CQW_ST_IDLE;
					end
				end
				default: state_q <= CQW_ST_IDLE;
			endcase
		end
	end

	// Frame latch; without a pop the previous frame is resent
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_ident <= 29'h0;
			tx_extended <= 1'b0;
			tx_remote <= 1'b0;
			tx_dlc <= 4'h0;
			tx_data <= 64'h0;
			last_valid_q <= 1'b0;
		end else if (pop) begin
			last_valid_q <= 1'b1;
			tx_extended <= q_id[rd_ptr_q][`CQW_EXT_BIT];
			tx_ident <= q_id[rd_ptr_q][`CQW_EXT_BIT] ?
				q_id[rd_ptr_q][28:0] :
				{18'h0, q_id[rd_ptr_q][10:0]};
			tx_remote <= (q_kind[rd_ptr_q][7:0] == CQW_KIND_REMOTE);
			tx_dlc <= q_kind[rd_ptr_q][`CQW_FKIND_LEN_LSB +: 4];
			tx_data <= (q_kind[rd_ptr_q][7:0] == CQW_KIND_REMOTE) ?
				64'h0 :
				len_mask(q_data[rd_ptr_q],
				q_kind[rd_ptr_q][`CQW_FKIND_LEN_LSB +: 8]);
		end
	end

	// ------------------------------------------------------------------
	// Transmit-complete state
	// ------------------------------------------------------------------
	// A new enqueue beats a completion in the same cycle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			txc_q <= 1'b1;
			run_d1_q <= 1'b0;
		end else begin
			run_d1_q <= run;
			if (accept) begin
				txc_q <= 1'b0;
			end else if (run_rise && count_q == '0 &&
				state_q == CQW_ST_IDLE) begin
				txc_q <= 1'b1;
			end else if (sent_ok && count_q == '0) begin
				txc_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------------
	always_comb begin
		isr_set = '0;
		isr_set[`CQW_IRQ_OVF] = ovf_ev;
		isr_set[`CQW_IRQ_SIZE] = enq_req & ~size_ok;
		isr_set[`CQW_IRQ_KIND] = enq_req & size_ok & ~kind_ok;
		isr_set[`CQW_IRQ_SENT] = sent_ok;
	end

	// Write one to clear; a new event wins over its clear
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			isr_q <= '0;
		end else if (wr_en && wb_adr_i == `CQW_ADR_ISR) begin
			isr_q <= (isr_q & ~(wb_dat_i[`CQW_IRQ_W-1:0] &
				{`CQW_IRQ_W{wb_sel_i[0]}})) | isr_set;
		end else begin
			isr_q <= isr_q | isr_set;
		end
	end

	assign irq = |(isr_q & imr_q);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_enq_nowait: assert property (push && !pop |=>
		count_q == $past(count_q) + 1'b1)
		else $error("accepted item not in queue next cycle");
	a_done_cause: assert property (!txc_q && !accept &&
		!(count_q == '0 && (sent_ok || run_rise)) |=> !txc_q)
		else $error("complete state rose without cause");
	a_done_hold: assert property (txc_q && !accept |=> txc_q)
		else $error("complete state dropped without enqueue");
	a_done_clear: assert property (accept |=> !txc_q)
		else $error("complete state not cleared by enqueue");
	a_start_true: assert property (run_rise && !accept &&
		count_q == '0 && state_q == CQW_ST_IDLE |=> txc_q)
		else $error("complete state false at start");
	a_repeat_send: assert property (tick && !tx_valid &&
		last_valid_q && count_q == '0 |=> tx_valid &&
		$stable(tx_ident) && $stable(tx_data))
		else $error("periodic resend missing");
	a_ovf_keep: assert property (ovf_ev && !pop |=>
		count_q == $past(count_q) && isr_q[`CQW_IRQ_OVF])
		else $error("overflow changed queue or not flagged");
	a_zero_noovf: assert property (zero_mode |->
		!ovf_ev && count_q <= 1)
		else $error("overflow or growth in zero depth");
	a_size_rej: assert property (enq_req && !size_ok |->
		!accept ##1 isr_q[`CQW_IRQ_SIZE])
		else $error("wrong size item accepted");
	a_std_id: assert property (tx_valid && !tx_extended |->
		tx_ident[28:11] == '0)
		else $error("standard identifier wider than 11 bits");
	a_remote_nodata: assert property (tx_valid && tx_remote |->
		tx_data == 64'h0)
		else $error("remote frame carries payload");
	a_retry_hold: assert property (tx_valid && tx_done &&
		!(tx_arb_won && tx_acked) |=> tx_valid && $stable(tx_ident))
		else $error("failed attempt not retried");

endmodule : cqw_tx_queue

// File: test/cqw_can_node_model.sv
// Behavioural CAN controller that answers the queue writer's requests
`timescale 1ns/1ps

module cqw_can_node_model (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic tx_valid,
	input wire logic refuse,
	input wire logic slow,
	output logic tx_done,
	output logic tx_arb_won,
	output logic tx_acked
);
	logic [4:0] wait_q;
	logic pat_q;

	// -------------------------------------------------------------
	// Attempt timing and outcome
	// -------------------------------------------------------------
	// Qualifiers toggle outside tx_done, so stale values never match
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wait_q <= 5'h00;
			pat_q <= 1'b0;
			tx_done <= 1'b0;
			tx_arb_won <= 1'b0;
			tx_acked <= 1'b0;
		end else begin
			pat_q <= ~pat_q;
			tx_done <= 1'b0;
			tx_arb_won <= pat_q;
			tx_acked <= ~pat_q;
			if (tx_valid && !tx_done) begin
				if (wait_q >= (slow ? 5'h0C : 5'h02)) begin
					tx_done <= 1'b1;
					tx_arb_won <= 1'b1;
					tx_acked <= !refuse; // No acknowledge on refusal
					wait_q <= 5'h00;
				end else begin
					wait_q <= wait_q + 5'h01;
				end
			end else begin
				wait_q <= 5'h00;
			end
		end
	end
endmodule : cqw_can_node_model

// File: test/cqw_tx_queue_tb_top.sv
// Self-checking bench for the transmit queue writer
`timescale 1ns/1ps
`include "cqw_regs.svh"

module cqw_tx_queue_tb_top;
	logic clock, reset_n, cyc, stb, we, refuse, slow;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rd, lf;
	logic [31:0] rdat;
	logic ack, irq, tx_valid, tx_ext, tx_rem, tx_done, arb, acked;
	logic [28:0] tx_ident;
	logic [3:0] tx_dlc;
	logic [63:0] tx_data;
	logic [98:0] sent[$], expq[$], fa;
	int miscompares = 0, n_checks = 0;

	cqw_tx_queue #(.DEPTH(4)) cqw_tx_queue_i (.clock(clock),
		.reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .irq(irq), .tx_valid(tx_valid),
		.tx_ident(tx_ident), .tx_extended(tx_ext), .tx_remote(tx_rem),
		.tx_dlc(tx_dlc), .tx_data(tx_data), .tx_done(tx_done),
		.tx_arb_won(arb), .tx_acked(acked));
	cqw_can_node_model cqw_can_node_model_i (.clock(clock),
		.reset_n(reset_n), .tx_valid(tx_valid), .refuse(refuse),
		.slow(slow), .tx_done(tx_done), .tx_arb_won(arb), .tx_acked(acked));

	// -------------------------------------------------------------
	// Clock, frame monitor and watchdog
	// -------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Record each frame at its successful attempt
	always @(posedge clock) begin
		if (reset_n && tx_valid === 1'b1 && tx_done && arb && acked) begin
			sent.push_back({tx_ident, tx_ext, tx_rem, tx_dlc, tx_data});
		end
	end
	initial begin
		repeat (40000) @(posedge clock);
		miscompares++;
		give_verdict();
	end

	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	// Expected frame: identifier width, remote, length and masking
	function automatic logic [98:0] fx(logic [31:0] id, logic [7:0] k,
		logic [7:0] n, logic [63:0] d);
		logic [63:0] m;
		m = (k == 8'h01) ? 64'h0 : d & ~({64{1'b1}} << (n * 8));
		return {id[29] ? id[28:0] : {18'h0, id[10:0]}, id[29],
			k == 8'h01, n[3:0], m};
	endfunction : fx
	task automatic chk(logic [31:0] g, logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic chk_f(logic [98:0] g, logic [98:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk_f
	// Classic single cycle; release only after ack is sampled
	task automatic wb(logic [7:0] a, logic w, logic [31:0] d);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clock iff ack === 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	task automatic enq(logic [31:0] id, logic [7:0] k, logic [7:0] n,
		logic [63:0] d, logic [7:0] sz, logic keep);
		wb(`CQW_ADR_FID, 1, id);
		wb(`CQW_ADR_FKIND, 1, {16'h0, n, k});
		wb(`CQW_ADR_FDAT0, 1, d[31:0]);
		wb(`CQW_ADR_FDAT1, 1, d[63:32]);
		wb(`CQW_ADR_ENQ, 1, {24'h0, sz});
		if (keep) expq.push_back(fx(id, k, n, d));
	endtask : enq
	task automatic rst(int n);
		reset_n <= 1'b0;
		repeat (n) @(posedge clock);
		reset_n <= 1'b1;
		sent.delete();
		expq.delete();
	endtask : rst
	// Wait for n frames, then compare against the expected list
	task automatic drain(int n);
		for (int i = 0; i < 3000 && sent.size() < n; i++) @(posedge clock);
		repeat (40) @(posedge clock);
		chk(sent.size(), expq.size());
		foreach (expq[i]) if (i < sent.size()) chk_f(sent[i], expq[i]);
	endtask : drain
	task automatic endt(string s);
		$display("test %s done, checks %0d", s, n_checks);
	endtask : endt
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	// -------------------------------------------------------------
	// Test sequence
	// -------------------------------------------------------------
	initial begin
		{cyc, stb, we, refuse, slow} = 5'h00;
		adr = 8'h00;
		sel = 4'hF;
		wdat = 32'h0;
		lf = 32'h036216E6;
		rst(20);
		wb(`CQW_ADR_STAT, 0, 0);
		chk(rd[0], 1);
		enq(32'h0000_05A3, 8'h00, 8'h03, 64'h1122334455667788, 8'h18, 1);
		wb(`CQW_ADR_STAT, 0, 0);
		chk(rd[0], 0);
		wb(`CQW_ADR_CTRL, 1, 32'h1);
		// Item still pending after start: busy, not yet complete
		wb(`CQW_ADR_STAT, 0, 0);
		chk(rd, 32'h2);
		drain(1);
		wb(`CQW_ADR_STAT, 0, 0);
		chk(rd[0], 1);
		wb(`CQW_ADR_ISR, 0, 0);
		chk(rd, 32'h8);
		endt("basic");
		// Corners and random frames kept in order
		slow <= 1'b1;
		enq(32'h3FFF_FFFF, 8'h01, 8'h0F, 64'hFFFF, 8'h18, 1);
		enq(32'h2000_0001, 8'h00, 8'h08, 64'hA5A5A5A5DEADBEEF, 8'h18, 1);
		for (int i = 0; i < 3; i++) begin
			lf = lfsr(lfsr(lf));
			enq(lf & 32'h3FFF_FFFF, {7'h0, lf[3]}, {4'h0, lf[7:4]} % 9,
				{lf, ~lf}, 8'h18, 1);
		end
		drain(6);
		slow <= 1'b0;
		endt("order");
		// Refused acknowledge keeps the frame pending
		refuse <= 1'b1;
		enq(32'h7FF, 8'h00, 8'h01, 64'h42, 8'h18, 1);
		repeat (30) @(posedge clock);
		wb(`CQW_ADR_STAT, 0, 0);
		chk({tx_valid, rd[0]}, 2'b10);
		refuse <= 1'b0;
		drain(7);
		endt("refuse");
		// Full queue drops the offer and raises the interrupt
		rst(2);
		wb(`CQW_ADR_QLEN, 1, 32'h2);
		wb(`CQW_ADR_QLEN, 0, 0);
		chk(rd, 32'h2);
		for (int i = 0; i < 3; i++) enq(i, 8'h00, 8'h01, i, 8'h18, i < 2);
		wb(`CQW_ADR_ISR, 0, 0);
		chk(rd, 32'h1);
		chk(irq, 0);
		// The write lands on the ack edge; look one edge later
		wb(`CQW_ADR_IMR, 1, 32'h1);
		@(posedge clock);
		chk(irq, 1);
		wb(`CQW_ADR_ISR, 1, 32'h1);
		@(posedge clock);
		chk(irq, 0);
		wb(`CQW_ADR_CTRL, 1, 32'h1);
		drain(2);
		endt("overflow");
		// Bad size and unsupported kinds are rejected
		wb(`CQW_ADR_ISR, 1, 32'hF);
		enq(32'h1, 8'h00, 8'h01, 0, 8'h10, 0);
		wb(`CQW_ADR_ISR, 0, 0);
		chk(rd, 32'h2);
		wb(`CQW_ADR_ISR, 1, 32'h2);
		for (int k = 16; k < 19; k++) begin
			enq(32'h1, k, 8'h01, 0, 8'h18, 0);
			wb(`CQW_ADR_ISR, 0, 0);
			chk(rd, 32'h4);
			wb(`CQW_ADR_ISR, 1, 32'h4);
		end
		drain(2);
		endt("reject");
		// Zero depth keeps only the newest offer
		rst(2);
		wb(`CQW_ADR_QLEN, 1, 32'h0);
		enq(32'h11, 8'h00, 8'h02, 64'hAAAA, 8'h18, 0);
		enq(32'h22, 8'h00, 8'h02, 64'hBBBB, 8'h18, 1);
		wb(`CQW_ADR_ISR, 0, 0);
		chk(rd[0], 0);
		wb(`CQW_ADR_CTRL, 1, 32'h1);
		drain(1);
		endt("zero depth");
		// Periodic mode repeats the last frame while empty
		rst(2);
		wb(`CQW_ADR_PERIOD, 1, 32'd30);
		enq(32'h123, 8'h00, 8'h04, 64'h01020304, 8'h18, 1);
		wb(`CQW_ADR_CTRL, 1, 32'h3);
		repeat (130) @(posedge clock);
		chk(sent.size() >= 3, 1);
		foreach (sent[i]) chk_f(sent[i], expq[0]);
		fa = fx(32'h456, 8'h00, 8'h01, 64'h99);
		enq(32'h456, 8'h00, 8'h01, 64'h99, 8'h18, 0);
		repeat (100) @(posedge clock);
		chk_f(sent[$], fa);
		endt("periodic");
		give_verdict();
	end
endmodule : cqw_tx_queue_tb_top
